// >>> core/tfpc_consts.vh
// Constants for the timer flag and pin control block
`ifndef TFPC_CONSTS_VH
`define TFPC_CONSTS_VH
// Register addresses (byte addresses, one word each)
`define TFPC_ADDR_SYS1 8'h00
`define TFPC_ADDR_SYS2 8'h04
`define TFPC_ADDR_FLAG1 8'h08
`define TFPC_ADDR_FLAG2 8'h0c
`define TFPC_ADDR_IEN 8'h10
`define TFPC_ADDR_ACTL 8'h14
`define TFPC_ADDR_AFLG 8'h18
`define TFPC_ADDR_IOS 8'h1c
`define TFPC_ADDR_OCTL 8'h20
`define TFPC_ADDR_MASK 8'h24
`define TFPC_ADDR_DATA3 8'h28
`define TFPC_ADDR_DDR 8'h2c
`define TFPC_ADDR_PORT 8'h30
`define TFPC_ADDR_CNT 8'h34
`define TFPC_ADDR_ACNT 8'h38
`define TFPC_ADDR_CH0 8'h40
// Field positions
`define TFPC_SYS1_FFCA 4
`define TFPC_SYS2_COUNTER_RESET_ON_CH3_ENABLE 3
`define TFPC_SYS2_OVIE 7
`define TFPC_FLAG2_OVF 7
`define TFPC_ACTL_INIE 0
`define TFPC_ACTL_OVIE 1
`define TFPC_AFLG_IN 0
`define TFPC_AFLG_OV 1
// Reset values and the all-ones word
`define TFPC_RST_BYTE 8'h00
`define TFPC_RST_WORD 16'h0000
`define TFPC_ALL_ONES 16'hffff
`endif

// >>> core/tfpc_flag.v
// Sticky event flag with write-one clear and auto clear
module tfpc_flag (
    input wire i_ref_clk, // System clock
    input wire i_rstn, // Async reset, active low
    input wire i_set, // Event pulse
    input wire i_clr, // Clear pulse
    output reg o_flag // Flag state
);
    // Set wins over clear in the same cycle
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clr) begin
            o_flag <= 1'b0;
        end
    end
endmodule // tfpc_flag

// >>> core/tfpc_pin.v
// Direction and drive choice for one timer port pin
module tfpc_pin (
    input wire i_ios, // Pin in compare mode
    input wire i_om, // Output mode bit
    input wire i_ol, // Output level bit
    input wire i_mask, // Channel 3 mask bit
    input wire i_ddr, // Stored direction bit
    input wire i_latch, // Port output latch
    input wire i_oc_level, // Level from compare action
    output wire o_oe, // Pin is driven
    output wire o_val // Value driven
);
    wire comp_drive;
    // Compare function overrides direction bit
    assign comp_drive = i_ios & (i_om | i_ol | i_mask);
    assign o_oe = comp_drive | i_ddr;
    assign o_val = comp_drive ? i_oc_level : i_latch;
endmodule // tfpc_pin

// >>> core/tfpc_top.v
// Timer flags, interrupt requests and port pin control
//
// Notes on behaviour
// - A capture or compare event on a channel sets its event flag.
// - Channel flag clears on a written one or a fast clear; a written zero leaves it.
// - With fast clear, capture read or compare write clears channel flag.
// - A set channel flag never blocks later captures or compares.
// - Accumulator wrap from all ones to zero sets accumulator overflow flag.
// - Accumulator overflow flag requests interrupt if enabled; write one clears.
// - With fast clear, accumulator count access clears all accumulator flags.
// - Input flag set by event edge, or trailing gate edge in gated mode.
// - Accumulator input flag requests interrupt if enabled; write one clears.
// - Free-running counter wrap from all ones to zero sets overflow flag.
// - Overflow flag requests interrupt if enabled; write one clears.
// - Counter reset on channel 3 with compare all ones: no overflow.
// - With fast clear, counter access clears whole second flag register.
// - A set overflow flag never blocks later overflow detection.
// - Reset loads every register with its startup value.
// - Port read gives pin level for inputs, latch for outputs.
// - Compare mode with nonzero output action drives the pin.
// - Channel 3 mask bit forces compare pin to output, direction kept.
// - Compare overrides direction and stops port data driving the pin.
// - Channel 3 compare forces masked pins to its data; own action follows.
`include "tfpc_consts.vh"
module tfpc_top (
    input wire i_ref_clk, // System clock, 10 MHz
    input wire i_rstn, // Async reset, active low
    input wire [7:0] i_addr, // Register address
    input wire [31:0] i_wdata, // Write data
    input wire i_wr, // Write strobe
    input wire i_rd, // Read strobe
    output reg [31:0] o_rdata, // Read data, one cycle after strobe
    input wire [3:0] i_ch_event, // Capture or compare event pulses
    input wire [3:0] i_ch_level, // Compare action output levels
    input wire [15:0] i_cnt_value, // Free-running counter value
    input wire [15:0] i_acc_value, // Accumulator count value
    input wire i_acc_edge, // Selected accumulator edge pulse
    input wire i_gated_mode, // Accumulator in gated mode
    input wire i_gate_level, // Gate pin active level present
    input wire [3:0] i_pin, // Pin input levels
    output reg [3:0] o_pin, // Pin output values
    output reg [3:0] o_pin_oe, // Pin output enables
    output reg [3:0] o_ch_irq, // Channel interrupt requests
    output reg o_acc_ovf_irq, // Accumulator overflow request
    output reg o_acc_in_irq, // Accumulator input request
    output reg o_cnt_ovf_irq // Counter overflow request
);
    reg [7:0] sys1_reg;
    reg [7:0] sys2_reg;
    reg [7:0] ien_reg;
    reg [7:0] actl_reg;
    reg [7:0] ios_reg;
    reg [7:0] octl_reg;
    reg [7:0] mask_reg;
    reg [7:0] data3_reg;
    reg [7:0] ddr_reg;
    reg [7:0] port_reg;
    reg [15:0] cmp3_reg;
    reg [15:0] cnt_prev_reg;
    reg [15:0] acc_prev_reg;
    reg gate_prev_reg;
    reg [3:0] force_reg;
    reg [31:0] rdata_next;
    wire [3:0] ch_flag;
    wire acc_ovf_flag;
    wire acc_in_flag;
    wire cnt_ovf_flag;
    wire fast_flag_clear_enable;
    wire counter_reset_on_ch3_enable;
    wire [3:0] ch_clr;
    wire [3:0] ch_fast;
    wire acc_access;
    wire cnt_access;
    wire cnt_wrap;
    wire acc_wrap;
    wire acc_in_set;
    wire [3:0] pin_oe;
    wire [3:0] pin_val;
    wire [7:0] flag1_view;
    wire [7:0] flag2_view;
    wire [7:0] aflg_view;
    wire [7:0] port_view;
    wire cnt_ovf_set;
    wire cnt_ovf_clr;
    wire acc_ovf_clr;
    wire acc_in_clr;

    // Channel whose compare value is stored and drives the forcing
    localparam CH_CMP3 = 3;

    // Word address match for a channel value register
    function hit_ch;
        input [7:0] addr;
        input integer ch;
        begin
            hit_ch = (addr == (`TFPC_ADDR_CH0 + {4'h0, ch[1:0], 2'b00}));
        end
    endfunction

    // Wrap from all ones to zero between two samples
    // Needs both samples, so a counter parked at zero never flags
    function wrapped;
        input [15:0] prev;
        input [15:0] now;
        begin
            wrapped = (prev == `TFPC_ALL_ONES) && (now == `TFPC_RST_WORD);
        end
    endfunction

    // Write-one-to-clear hit on one flag bit of one register
    function clr_hit;
        input wr;
        input [7:0] addr;
        input [7:0] target;
        input wbit;
        begin
            clr_hit = wr && (addr == target) && wbit;
        end
    endfunction

    // Any read or write of one register; fast clear keys on this
    // for the counter and accumulator value registers
    function reg_access;
        input wr;
        input rd;
        input [7:0] addr;
        input [7:0] target;
        begin
            reg_access = (wr | rd) && (addr == target);
        end
    endfunction

    // Control bits, access decodes and wrap detects
    assign fast_flag_clear_enable = sys1_reg[`TFPC_SYS1_FFCA];
    assign counter_reset_on_ch3_enable = sys2_reg[`TFPC_SYS2_COUNTER_RESET_ON_CH3_ENABLE];
    assign acc_access = reg_access(i_wr, i_rd, i_addr, `TFPC_ADDR_ACNT);
    assign cnt_access = reg_access(i_wr, i_rd, i_addr, `TFPC_ADDR_CNT);
    assign cnt_wrap = wrapped(cnt_prev_reg, i_cnt_value);
    assign acc_wrap = wrapped(acc_prev_reg, i_acc_value);

    // Flag set and clear terms; a clash of both is settled in the
    // flag cell, where the set wins so no event is ever lost
    assign cnt_ovf_set = cnt_wrap && !(counter_reset_on_ch3_enable &&
        (cmp3_reg == `TFPC_ALL_ONES));
    assign cnt_ovf_clr = clr_hit(i_wr, i_addr, `TFPC_ADDR_FLAG2,
        i_wdata[`TFPC_FLAG2_OVF]) ||
        (fast_flag_clear_enable && cnt_access);
    assign acc_ovf_clr = clr_hit(i_wr, i_addr, `TFPC_ADDR_AFLG,
        i_wdata[`TFPC_AFLG_OV]) ||
        (fast_flag_clear_enable && acc_access);
    assign acc_in_clr = clr_hit(i_wr, i_addr, `TFPC_ADDR_AFLG,
        i_wdata[`TFPC_AFLG_IN]) ||
        (fast_flag_clear_enable && acc_access);

    // Fast clear per channel: capture read or compare write
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ch
            assign ch_fast[g] = fast_flag_clear_enable &&
                hit_ch(i_addr, g) && (ios_reg[g] ? i_wr : i_rd);
            assign ch_clr[g] = clr_hit(i_wr, i_addr, `TFPC_ADDR_FLAG1,
                i_wdata[g]) || ch_fast[g];
            // Events still flagged while set, nothing gates them
            tfpc_flag u_ch_flag (
                .i_ref_clk(i_ref_clk),
                .i_rstn(i_rstn),
                .i_set(i_ch_event[g]),
                .i_clr(ch_clr[g]),
                .o_flag(ch_flag[g])
            );
            // Pin drive choice; compare level is ch3 data while forced
            tfpc_pin u_pin (
                .i_ios(ios_reg[g]),
                .i_om(octl_reg[2 * g + 1]),
                .i_ol(octl_reg[2 * g]),
                .i_mask(mask_reg[g]),
                .i_ddr(ddr_reg[g]),
                .i_latch(port_reg[g]),
                .i_oc_level(force_reg[g] ? data3_reg[g] : i_ch_level[g]),
                .o_oe(pin_oe[g]),
                .o_val(pin_val[g])
            );
        end
    endgenerate

    // Counter overflow unless reset on channel 3 at all ones
    // A set flag never gates the set term, so later wraps still land
    tfpc_flag u_cnt_ovf (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_set(cnt_ovf_set),
        .i_clr(cnt_ovf_clr),
        .o_flag(cnt_ovf_flag)
    );

    // Accumulator overflow flag
    tfpc_flag u_acc_ovf (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_set(acc_wrap),
        .i_clr(acc_ovf_clr),
        .o_flag(acc_ovf_flag)
    );

    // Input flag: event edge, or trailing edge of gate level
    assign acc_in_set = i_gated_mode ? (gate_prev_reg && !i_gate_level)
        : i_acc_edge;
    tfpc_flag u_acc_in (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_set(acc_in_set),
        .i_clr(acc_in_clr),
        .o_flag(acc_in_flag)
    );

    // Readback views of flags and port
    // Outputs read back their latch, inputs their live pin
    assign flag1_view = {4'h0, ch_flag};
    assign flag2_view = {cnt_ovf_flag, 7'h00};
    assign aflg_view = {6'h00, acc_ovf_flag, acc_in_flag};
    assign port_view = {4'h0, (ddr_reg[3:0] & port_reg[3:0]) |
        (~ddr_reg[3:0] & i_pin)};

    // Previous samples for wrap and trailing-edge detection; the gate
    // sample resets low like an idle gate, so no edge follows reset
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_prev_reg <= `TFPC_RST_WORD;
            acc_prev_reg <= `TFPC_RST_WORD;
            gate_prev_reg <= 1'b0;
        end else begin
            cnt_prev_reg <= i_cnt_value;
            acc_prev_reg <= i_acc_value;
            gate_prev_reg <= i_gate_level;
        end
    end

    // Software-written control registers
    // Writes to unmapped addresses fall through and are dropped
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sys1_reg <= `TFPC_RST_BYTE;
            sys2_reg <= `TFPC_RST_BYTE;
            ien_reg <= `TFPC_RST_BYTE;
            actl_reg <= `TFPC_RST_BYTE;
            ios_reg <= `TFPC_RST_BYTE;
            octl_reg <= `TFPC_RST_BYTE;
            mask_reg <= `TFPC_RST_BYTE;
            data3_reg <= `TFPC_RST_BYTE;
            ddr_reg <= `TFPC_RST_BYTE;
            port_reg <= `TFPC_RST_BYTE;
            cmp3_reg <= `TFPC_RST_WORD;
        end else begin
            if (i_wr) begin
                case (i_addr)
                    `TFPC_ADDR_SYS1: sys1_reg <= i_wdata[7:0];
                    `TFPC_ADDR_SYS2: sys2_reg <= i_wdata[7:0];
                    `TFPC_ADDR_IEN: ien_reg <= i_wdata[7:0];
                    `TFPC_ADDR_ACTL: actl_reg <= i_wdata[7:0];
                    `TFPC_ADDR_IOS: ios_reg <= i_wdata[7:0];
                    `TFPC_ADDR_OCTL: octl_reg <= i_wdata[7:0];
                    `TFPC_ADDR_MASK: mask_reg <= i_wdata[7:0];
                    `TFPC_ADDR_DATA3: data3_reg <= i_wdata[7:0];
                    `TFPC_ADDR_DDR: ddr_reg <= i_wdata[7:0];
                    `TFPC_ADDR_PORT: port_reg <= i_wdata[7:0];
                    default: begin
                        if (hit_ch(i_addr, CH_CMP3)) begin
                            cmp3_reg <= i_wdata[15:0];
                        end
                    end
                endcase
            end
        end
    end

    // Channel 3 compare forces masked pins until their own action
    // A later channel 3 compare reloads the set from the mask
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            force_reg <= 4'h0;
        end else if (i_ch_event[3] && ios_reg[3]) begin
            force_reg <= mask_reg[3:0] & ios_reg[3:0];
        end else begin
            force_reg <= force_reg & ~(i_ch_event & ios_reg[3:0]);
        end
    end

    // Read mux; unmapped addresses read zero
    // Channels 0 to 2 keep no value here and read zero
    always @* begin
        rdata_next = 32'h0000_0000;
        case (i_addr)
            `TFPC_ADDR_SYS1: rdata_next = {24'h0, sys1_reg};
            `TFPC_ADDR_SYS2: rdata_next = {24'h0, sys2_reg};
            `TFPC_ADDR_FLAG1: rdata_next = {24'h0, flag1_view};
            `TFPC_ADDR_FLAG2: rdata_next = {24'h0, flag2_view};
            `TFPC_ADDR_IEN: rdata_next = {24'h0, ien_reg};
            `TFPC_ADDR_ACTL: rdata_next = {24'h0, actl_reg};
            `TFPC_ADDR_AFLG: rdata_next = {24'h0, aflg_view};
            `TFPC_ADDR_IOS: rdata_next = {24'h0, ios_reg};
            `TFPC_ADDR_OCTL: rdata_next = {24'h0, octl_reg};
            `TFPC_ADDR_MASK: rdata_next = {24'h0, mask_reg};
            `TFPC_ADDR_DATA3: rdata_next = {24'h0, data3_reg};
            `TFPC_ADDR_DDR: rdata_next = {24'h0, ddr_reg};
            `TFPC_ADDR_PORT: rdata_next = {24'h0, port_view};
            `TFPC_ADDR_CNT: rdata_next = {16'h0, i_cnt_value};
            `TFPC_ADDR_ACNT: rdata_next = {16'h0, i_acc_value};
            default: begin
                if (hit_ch(i_addr, CH_CMP3)) begin
                    rdata_next = {16'h0, cmp3_reg};
                end
            end
        endcase
    end

    // Registered outputs: read data, pins, interrupt requests
    // Requests lag their flag by one cycle so each comes from a flop
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 32'h0000_0000;
            o_pin <= 4'h0;
            o_pin_oe <= 4'h0;
            o_ch_irq <= 4'h0;
            o_acc_ovf_irq <= 1'b0;
            o_acc_in_irq <= 1'b0;
            o_cnt_ovf_irq <= 1'b0;
        end else begin
            o_rdata <= i_rd ? rdata_next : 32'h0000_0000;
            o_pin <= pin_val;
            o_pin_oe <= pin_oe;
            o_ch_irq <= ch_flag & ien_reg[3:0];
            o_acc_ovf_irq <= acc_ovf_flag &
                actl_reg[`TFPC_ACTL_OVIE];
            o_acc_in_irq <= acc_in_flag &
                actl_reg[`TFPC_ACTL_INIE];
            o_cnt_ovf_irq <= cnt_ovf_flag &
                sys2_reg[`TFPC_SYS2_OVIE];
        end
    end
endmodule // tfpc_top

// >>> sim/tfpc_pin_world.sv
// Model of the outside world on the timer port pins
module tfpc_pin_world (
    input wire i_ref_clk, // Clock
    input wire [3:0] i_drv, // Device pin values
    input wire [3:0] i_oe, // Device pin enables
    input wire [3:0] i_ext_en, // Outside party drives pin
    input wire [3:0] i_ext_val, // Outside party level
    output wire [3:0] o_level // Level seen on the pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] float_reg = 4'h0;
    // Undriven pins wander every cycle, never keep a stale level
    always @(posedge i_ref_clk) begin
        float_reg <= ~o_level;
    end
    // Wire level from both parties, device first
    assign o_level = (i_oe & i_drv) |
        (~i_oe & ((i_ext_en & i_ext_val) | (~i_ext_en & float_reg)));
endmodule // tfpc_pin_world

// >>> sim/tfpc_checker_assertions.sv
// Port checker for flag, request and pin timing
`include "tfpc_consts.vh"
module tfpc_checker (
    input wire i_ref_clk, // Clock
    input wire i_rstn, // Reset, active low
    input wire [7:0] i_addr, // Address
    input wire [31:0] i_wdata, // Write data
    input wire i_wr, // Write strobe
    input wire i_rd, // Read strobe
    input wire [31:0] o_rdata, // Read data
    input wire [3:0] i_ch_event, // Channel events
    input wire [15:0] i_cnt_value, // Counter value
    input wire [15:0] i_acc_value, // Accumulator value
    input wire [3:0] o_ch_irq, // Channel requests
    input wire o_acc_ovf_irq, // Accumulator overflow request
    input wire o_cnt_ovf_irq, // Counter overflow request
    input wire [3:0] o_pin_oe // Pin enables
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [15:0] cnt_prev_reg;
    reg [15:0] acc_prev_reg;
    wire cnt_wrap;
    wire acc_wrap;
    // Own previous samples to spot wraps
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_prev_reg <= 16'h0000;
            acc_prev_reg <= 16'h0000;
        end else begin
            cnt_prev_reg <= i_cnt_value;
            acc_prev_reg <= i_acc_value;
        end
    end
    assign cnt_wrap = (cnt_prev_reg == 16'hffff) && (i_cnt_value == 16'h0);
    assign acc_wrap = (acc_prev_reg == 16'hffff) && (i_acc_value == 16'h0);
    default clocking cb @(posedge i_ref_clk); endclocking
    // Channel 0 write-one clear with no event around it
    sequence s_clr0;
        (i_wr && i_addr == `TFPC_ADDR_FLAG1 && i_wdata[0] && !i_ch_event[0])
            ##1 !i_ch_event[0];
    endsequence
    AST_RDATA_IDLE: assert property (
        disable iff (!i_rstn) !$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not idle");
    AST_RESET_QUIET: assert property (
        !i_rstn |-> o_ch_irq == 4'h0 && o_pin_oe == 4'h0 && !o_cnt_ovf_irq)
        else $error("outputs active in reset");
    AST_CH_CLR: assert property (
        disable iff (!i_rstn) (o_ch_irq[0] ##0 s_clr0) |=> !o_ch_irq[0])
        else $error("channel flag not cleared");
    AST_CH_KEEP: assert property (
        disable iff (!i_rstn) o_ch_irq[0] && !$past(i_wr) && !$past(i_rd)
        && i_wr && i_addr == `TFPC_ADDR_FLAG1 && !i_wdata[0]
        |=> o_ch_irq[0] [*2])
        else $error("zero write cleared channel flag");
    AST_CH_ROSE: assert property (
        disable iff (!i_rstn) $rose(o_ch_irq[0])
        |-> $past(i_ch_event[0], 2) || $past(i_wr, 2))
        else $error("channel request without cause");
    AST_CH_FELL: assert property (
        disable iff (!i_rstn) $fell(o_ch_irq[0])
        |-> $past(i_wr, 2) || $past(i_rd, 2))
        else $error("channel request dropped alone");
    AST_CNT_ROSE: assert property (
        disable iff (!i_rstn) $rose(o_cnt_ovf_irq)
        |-> $past(cnt_wrap, 2) || $past(i_wr, 2))
        else $error("overflow request without wrap");
    AST_CNT_FELL: assert property (
        disable iff (!i_rstn) $fell(o_cnt_ovf_irq)
        |-> $past(i_wr, 2) || $past(i_rd, 2))
        else $error("overflow request dropped alone");
    AST_ACC_ROSE: assert property (
        disable iff (!i_rstn) $rose(o_acc_ovf_irq)
        |-> $past(acc_wrap, 2) || $past(i_wr, 2))
        else $error("accumulator request without wrap");
    AST_OE_STABLE: assert property (
        disable iff (!i_rstn) !$stable(o_pin_oe) |-> $past(i_wr, 2))
        else $error("pin enable moved without write");
endmodule // tfpc_checker
bind tfpc_top tfpc_checker u_chk (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_ch_event(i_ch_event), .i_cnt_value(i_cnt_value),
    .i_acc_value(i_acc_value), .o_ch_irq(o_ch_irq),
    .o_acc_ovf_irq(o_acc_ovf_irq), .o_cnt_ovf_irq(o_cnt_ovf_irq),
    .o_pin_oe(o_pin_oe));

// >>> sim/tb_timer_flag_and_pin_control.sv
// Self-checking bench of timer flags, requests and pins
`include "tfpc_consts.vh"
module tb_timer_flag_and_pin_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, aedge = 0, gmode = 0, glvl = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] ev = 4'h0, lvl = 4'h0, ext_en = 4'hf, ext_val = 4'h0;
    logic [15:0] cnt = 16'h0, acc = 16'h0;
    wire [31:0] rdata;
    wire [3:0] pin_in, pin, oe, chirq;
    wire aovf, ain, covf;
    int n_fail = 0;
    int compares = 0;
    tfpc_top dut (.i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_ch_event(ev), .i_ch_level(lvl), .i_cnt_value(cnt),
        .i_acc_value(acc), .i_acc_edge(aedge), .i_gated_mode(gmode),
        .i_gate_level(glvl), .i_pin(pin_in), .o_pin(pin), .o_pin_oe(oe),
        .o_ch_irq(chirq), .o_acc_ovf_irq(aovf), .o_acc_in_irq(ain),
        .o_cnt_ovf_irq(covf));
    tfpc_pin_world world (.i_ref_clk(clk), .i_drv(pin), .i_oe(oe),
        .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(pin_in));
    // Clock, 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp,
            input logic [31:0] m = 32'hffffffff);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata & m, exp);
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 4'h0;
    endtask
    // Counter or accumulator steps from all ones to zero
    task automatic wrap(input bit a);
        @(posedge clk);
        if (a) acc <= 16'hffff; else cnt <= 16'hffff;
        @(posedge clk);
        if (a) acc <= 16'h0; else cnt <= 16'h0;
        hold(3);
    endtask
    task automatic t_chan();
        bus_wr(`TFPC_ADDR_IEN, 32'hf);
        for (int g = 0; g < 4; g++) begin
            pulse(4'h1 << g);
            hold(1);
            chk(chirq, 32'h1 << g);
            bus_wr(`TFPC_ADDR_FLAG1, 32'h0);
            pulse(4'h1 << g);
            bus_rd(`TFPC_ADDR_FLAG1, 32'h1 << g);
            bus_wr(`TFPC_ADDR_FLAG1, 32'h1 << g);
            hold(1);
            chk(chirq, 32'h0);
        end
        $display("channel flags done");
    endtask
    task automatic t_fast();
        bus_wr(`TFPC_ADDR_SYS1, 32'h10);
        bus_wr(`TFPC_ADDR_IOS, 32'h2);
        pulse(4'h3);
        bus_rd(`TFPC_ADDR_FLAG1, 32'h3);
        bus_rd(`TFPC_ADDR_CH0, 32'h0);
        bus_wr(`TFPC_ADDR_CH0 + 8'h04, 32'h0);
        bus_rd(`TFPC_ADDR_FLAG1, 32'h0, 32'h3);
        bus_wr(`TFPC_ADDR_SYS1, 32'h0);
        bus_wr(`TFPC_ADDR_IOS, 32'h0);
        $display("fast clear done");
    endtask
    task automatic t_cnt();
        bus_wr(`TFPC_ADDR_SYS2, 32'h80);
        wrap(0);
        bus_rd(`TFPC_ADDR_FLAG2, 32'h80);
        chk(covf, 32'h1);
        bus_wr(`TFPC_ADDR_FLAG2, 32'h80);
        bus_rd(`TFPC_ADDR_FLAG2, 32'h0);
        wrap(0);
        wrap(0);
        bus_rd(`TFPC_ADDR_FLAG2, 32'h80);
        bus_wr(`TFPC_ADDR_SYS1, 32'h10);
        bus_rd(`TFPC_ADDR_CNT, 32'h0);
        bus_rd(`TFPC_ADDR_FLAG2, 32'h0);
        bus_wr(`TFPC_ADDR_SYS1, 32'h0);
        bus_wr(`TFPC_ADDR_CH0 + 8'h0c, 32'hffff);
        bus_wr(`TFPC_ADDR_SYS2, 32'h88);
        wrap(0);
        bus_rd(`TFPC_ADDR_FLAG2, 32'h0);
        bus_wr(`TFPC_ADDR_SYS2, 32'h0);
        $display("counter overflow done");
    endtask
    task automatic t_acc();
        bus_wr(`TFPC_ADDR_ACTL, 32'h3);
        wrap(1);
        bus_rd(`TFPC_ADDR_AFLG, 32'h2);
        chk(aovf, 32'h1);
        @(posedge clk);
        aedge <= 1'b1;
        @(posedge clk);
        aedge <= 1'b0;
        bus_rd(`TFPC_ADDR_AFLG, 32'h3);
        chk(ain, 32'h1);
        bus_wr(`TFPC_ADDR_AFLG, 32'h3);
        bus_rd(`TFPC_ADDR_AFLG, 32'h0);
        @(posedge clk);
        gmode <= 1'b1;
        glvl <= 1'b1;
        repeat (2) @(posedge clk);
        glvl <= 1'b0;
        bus_rd(`TFPC_ADDR_AFLG, 32'h1);
        bus_wr(`TFPC_ADDR_SYS1, 32'h10);
        wrap(1);
        bus_rd(`TFPC_ADDR_ACNT, 32'h0);
        bus_rd(`TFPC_ADDR_AFLG, 32'h0);
        bus_wr(`TFPC_ADDR_SYS1, 32'h0);
        gmode <= 1'b0;
        $display("accumulator flags done");
    endtask
    task automatic t_pins();
        @(posedge clk);
        ext_val <= 4'h5;
        bus_rd(`TFPC_ADDR_PORT, 32'h5);
        bus_wr(`TFPC_ADDR_PORT, 32'ha);
        bus_wr(`TFPC_ADDR_DDR, 32'h3);
        bus_rd(`TFPC_ADDR_PORT, 32'h6);
        chk({oe, pin[1:0]}, 32'h0e);
        bus_wr(`TFPC_ADDR_DDR, 32'h0);
        bus_wr(`TFPC_ADDR_IOS, 32'hf);
        bus_wr(`TFPC_ADDR_OCTL, 32'h4);
        bus_wr(`TFPC_ADDR_MASK, 32'h6);
        bus_wr(`TFPC_ADDR_DATA3, 32'h6);
        hold(2);
        chk({oe, pin[1]}, 32'h0c);
        bus_rd(`TFPC_ADDR_DDR, 32'h0);
        pulse(4'h8);
        hold(2);
        chk(pin[2:1], 32'h3);
        pulse(4'h2);
        hold(2);
        chk(pin[2:1], 32'h2);
        $display("pin control done");
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        test_done();
    end
    // Reset, then every scenario in turn
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        for (logic [7:0] a = 0; a <= 8'h4c; a += 8'h04) begin
            bus_rd(a, 32'h0);
        end
        bus_rd(8'hfc, 32'h0);
        chk({chirq, oe, aovf, ain, covf}, 32'h0);
        $display("reset values done");
        t_chan();
        t_fast();
        t_cnt();
        t_acc();
        t_pins();
        test_done();
    end
endmodule // tb_timer_flag_and_pin_control
